// >>> hw/urs_params.svh
// Register offsets, field positions and reset values of the receive status block.
// Assumes inclusion by bare name from the design files.
`ifndef URS_PARAMS_SVH
`define URS_PARAMS_SVH

// Byte offsets on the APB register bus.
`define URS_OFS_STATUS      8'h00
`define URS_OFS_CTRL        8'h04
`define URS_OFS_DATA        8'h08
`define URS_OFS_EV_STATUS   8'h0c
`define URS_OFS_EV_MASK     8'h10

// Field positions in the status and control register.
`define URS_STA_THR_HI      7
`define URS_STA_THR_LO      6
`define URS_STA_ADDR_DET    5
`define URS_STA_IDLE        4
`define URS_STA_PARITY_ERROR_FLAG        3
`define URS_STA_FRAMING_ERROR_FLAG        2
`define URS_STA_OVR         1
`define URS_STA_AVAIL       0

// Field positions in the extra control and event registers.
`define URS_CTRL_NINE_BIT   0
`define URS_EV_THRESHOLD    0
`define URS_EV_OVERRUN      1

// Reset values.
`define URS_RST_THR         2'h0
`define URS_RST_EV          2'h0

`endif

// >>> hw/urs_pkg.sv
// Types shared by the receive status block and its buffer.
// Assumes nothing of its surroundings.
package urs_pkg;

    // One completed character as handed over by the receive shift register.
    typedef struct packed {
        logic       framing_error_flag;
        logic       parity_error_flag;
        logic [8:0] data;
    } urs_rx_char_s;

    // Receive interrupt threshold selections.
    typedef enum logic [1:0] {
        URS_THR_ANY_A = 2'h0,
        URS_THR_ANY_B = 2'h1,
        URS_THR_3Q    = 2'h2,
        URS_THR_FULL  = 2'h3
    } urs_thr_e;

endpackage : urs_pkg

// >>> hw/urs_rx_fifo.sv
// Small receive buffer held in flip-flops, with flush.
// Assumes one clock and a synchronous active-high reset; push when full is ignored unless a pop comes in the same cycle.
`timescale 1ns/100ps
`default_nettype none

module urs_rx_fifo #(
    parameter int  WIDTH = 11,
    parameter int  DEPTH = 4,
    localparam int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    localparam int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             push_in,
    input  wire logic             pop_in,
    input  wire logic             flush_in,
    input  wire logic [WIDTH-1:0] data_in,
    output logic      [WIDTH-1:0] head_out,
    output logic      [CW-1:0]    count_out,
    output logic                  empty_out,
    output logic                  full_out
);

    logic [WIDTH-1:0] mem_ff     [DEPTH];
    logic [WIDTH-1:0] nxt_mem    [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    nxt_wr_ptr;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW-1:0]    nxt_rd_ptr;
    logic [CW-1:0]    cnt_ff;
    logic [CW-1:0]    nxt_cnt;
    logic             do_push;
    logic             do_pop;

    // Pointer and count update; a flush wins over any push or pop in the same cycle.
    always_comb begin
        nxt_mem    = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_cnt    = cnt_ff;
        do_pop     = pop_in && (cnt_ff != '0);
        do_push    = push_in && ((cnt_ff != CW'(DEPTH)) || do_pop);
        if (flush_in) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_cnt    = '0;
        end else begin
            if (do_push) begin
                nxt_mem[wr_ptr_ff] = data_in;
                nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
            end
            if (do_pop) begin
                nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
            end
            nxt_cnt = cnt_ff + CW'(do_push) - CW'(do_pop);
        end
    end

    // Storage and pointer registers.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            mem_ff    <= nxt_mem;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff    <= nxt_cnt;
        end
    end

    assign head_out  = mem_ff[rd_ptr_ff];
    assign count_out = cnt_ff;
    assign empty_out = (cnt_ff == '0);
    assign full_out  = (cnt_ff == CW'(DEPTH));

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // The count never passes the depth and a flush always empties the buffer.
    property p_fifo_bound;
        cnt_ff <= CW'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("Buffer count above depth.");

    property p_fifo_flush;
        flush_in |=> (cnt_ff == '0);
    endproperty
    a_fifo_flush: assert property (p_fifo_flush) else $error("Flush did not empty the buffer.");

endmodule : urs_rx_fifo

`default_nettype wire

// >>> hw/urs_rx_status.sv
// Receive status, threshold interrupt and buffer control of the serial receiver, with an APB slave.
// Assumes the receive shift register runs on clk_in and hands over one character per valid pulse.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "urs_params.svh"

module urs_rx_status #(
    parameter int  DEPTH = 4,
    localparam int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire logic                  rx_char_valid_in,
    input  wire urs_pkg::urs_rx_char_s rx_char_in,
    input  wire logic                  rx_busy_in,
    output logic                       rx_flush_out,
    output logic                       irq_out
);

    logic [1:0]            thr_sel_ff;
    logic [1:0]            nxt_thr_sel;
    logic                  addr_det_ff;
    logic                  nxt_addr_det;
    logic                  nine_bit_ff;
    logic                  nxt_nine_bit;
    logic                  ovr_ff;
    logic                  nxt_ovr;
    logic                  idle_ff;
    logic [1:0]            ev_st_ff;
    logic [1:0]            nxt_ev_st;
    logic [1:0]            ev_mask_ff;
    logic [1:0]            nxt_ev_mask;
    logic                  irq_ff;
    logic                  nxt_irq;
    logic                  flush_ff;
    logic                  nxt_flush;
    logic                  pready_ff;
    logic                  nxt_pready;
    logic                  pslverr_ff;
    logic                  nxt_pslverr;
    logic [31:0]           prdata_ff;
    logic [31:0]           nxt_prdata;
    logic                  rd_ok_ff;
    logic                  nxt_rd_ok;
    logic                  done;
    logic                  wr;
    logic                  rd;
    logic                  accept;
    logic                  push;
    logic                  pop;
    logic                  ovr_set;
    logic                  ovr_clear;
    logic                  thr_hit;
    logic [CW-1:0]         fill;
    logic [CW-1:0]         cnt;
    logic                  empty;
    logic                  full;
    logic [15:0]           sta_word;
    logic                  head_parity_error_flag;
    logic                  head_framing_error_flag;
    urs_pkg::urs_rx_char_s head;

    // Character buffer; error bits travel with each character to the head.
    urs_rx_fifo #(
        .WIDTH ($bits(urs_pkg::urs_rx_char_s)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .push_in   (push),
        .pop_in    (pop),
        .flush_in  (ovr_clear),
        .data_in   (rx_char_in),
        .head_out  (head),
        .count_out (cnt),
        .empty_out (empty),
        .full_out  (full)
    );

    // Bus strobes: a transfer completes at the edge where the slave shows ready.
    assign done = psel_in && penable_in && pready_ff;
    assign wr   = done && pwrite_in;
    assign rd   = done && !pwrite_in;

    // Receive path. Filtering applies only in 9-bit mode, so 8-bit traffic is never lost to it.
    assign accept    = rx_char_valid_in && (!(addr_det_ff && nine_bit_ff) || rx_char_in.data[8]);
    assign push      = accept && !full && !ovr_ff;
    assign ovr_set   = accept && full;
    assign ovr_clear = wr && (paddr_in == `URS_OFS_STATUS) && !pwdata_in[`URS_STA_OVR]
                       && ovr_ff && !ovr_set;
    assign pop       = rd && (paddr_in == `URS_OFS_DATA) && rd_ok_ff && !ovr_clear;
    assign fill      = cnt + CW'(push) - CW'(pop);

    // Threshold decode on the fill level that a transfer leaves behind.
    always_comb begin
        thr_hit = 1'b0;
        case (urs_pkg::urs_thr_e'(thr_sel_ff))
            urs_pkg::URS_THR_FULL: thr_hit = push && (fill == CW'(DEPTH));
            urs_pkg::URS_THR_3Q:   thr_hit = push && (fill == CW'(DEPTH * 3 / 4));
            default:               thr_hit = push;
        endcase
    end

    // Head flags read as zero while the buffer holds nothing.
    assign head_parity_error_flag = !empty && head.parity_error_flag;
    assign head_framing_error_flag = !empty && head.framing_error_flag;
    assign sta_word  = {8'h00, thr_sel_ff, addr_det_ff, idle_ff, head_parity_error_flag, head_framing_error_flag, ovr_ff, !empty};

    // Control, flags and event registers. An event in the cycle of its clear wins over the clear.
    always_comb begin
        nxt_thr_sel  = thr_sel_ff;
        nxt_addr_det = addr_det_ff;
        nxt_nine_bit = nine_bit_ff;
        nxt_ev_mask  = ev_mask_ff;
        nxt_ev_st    = ev_st_ff;
        nxt_ovr      = ovr_ff;
        if (wr) begin
            case (paddr_in)
                `URS_OFS_STATUS: begin
                    nxt_thr_sel  = pwdata_in[`URS_STA_THR_HI:`URS_STA_THR_LO];
                    nxt_addr_det = pwdata_in[`URS_STA_ADDR_DET];
                end
                `URS_OFS_CTRL:      nxt_nine_bit = pwdata_in[`URS_CTRL_NINE_BIT];
                `URS_OFS_EV_STATUS: nxt_ev_st    = ev_st_ff & ~pwdata_in[1:0];
                `URS_OFS_EV_MASK:   nxt_ev_mask  = pwdata_in[1:0];
                default: ;
            endcase
        end
        if (ovr_clear) begin
            nxt_ovr = 1'b0;
        end
        if (ovr_set) begin
            nxt_ovr = 1'b1;
        end
        nxt_ev_st[`URS_EV_THRESHOLD] = nxt_ev_st[`URS_EV_THRESHOLD] | thr_hit;
        nxt_ev_st[`URS_EV_OVERRUN]   = nxt_ev_st[`URS_EV_OVERRUN] | (ovr_set && !ovr_ff);
        nxt_irq   = |(nxt_ev_st & nxt_ev_mask);
        nxt_flush = ovr_clear;
    end

    // Bus answer: one wait state, so read data are captured from settled state.
    always_comb begin
        nxt_pready  = psel_in && penable_in && !pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata  = 32'h0000_0000;
        nxt_rd_ok   = 1'b0;
        if (nxt_pready) begin
            case (paddr_in)
                `URS_OFS_STATUS:    nxt_prdata = {16'h0000, sta_word};
                `URS_OFS_CTRL:      nxt_prdata = {31'h0000_0000, nine_bit_ff};
                `URS_OFS_DATA: begin
                    nxt_prdata = empty ? 32'h0000_0000 : {23'h00_0000, head.data};
                    nxt_rd_ok  = !empty;
                end
                `URS_OFS_EV_STATUS: nxt_prdata = {30'h0000_0000, ev_st_ff};
                `URS_OFS_EV_MASK:   nxt_prdata = {30'h0000_0000, ev_mask_ff};
                default:            nxt_pslverr = 1'b1;
            endcase
        end
    end

    // All state registers; the idle flag samples a same-clock busy level.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            thr_sel_ff  <= `URS_RST_THR;
            addr_det_ff <= 1'b0;
            nine_bit_ff <= 1'b0;
            ovr_ff      <= 1'b0;
            idle_ff     <= 1'b1;
            ev_st_ff    <= `URS_RST_EV;
            ev_mask_ff  <= `URS_RST_EV;
            irq_ff      <= 1'b0;
            flush_ff    <= 1'b0;
            pready_ff   <= 1'b0;
            pslverr_ff  <= 1'b0;
            prdata_ff   <= 32'h0000_0000;
            rd_ok_ff    <= 1'b0;
        end else begin
            thr_sel_ff  <= nxt_thr_sel;
            addr_det_ff <= nxt_addr_det;
            nine_bit_ff <= nxt_nine_bit;
            ovr_ff      <= nxt_ovr;
            idle_ff     <= !rx_busy_in;
            ev_st_ff    <= nxt_ev_st;
            ev_mask_ff  <= nxt_ev_mask;
            irq_ff      <= nxt_irq;
            flush_ff    <= nxt_flush;
            pready_ff   <= nxt_pready;
            pslverr_ff  <= nxt_pslverr;
            prdata_ff   <= nxt_prdata;
            rd_ok_ff    <= nxt_rd_ok;
        end
    end

    assign prdata_out   = prdata_ff;
    assign pready_out   = pready_ff;
    assign pslverr_out  = pslverr_ff;
    assign rx_flush_out = flush_ff;
    assign irq_out      = irq_ff;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_thr_full;
        (thr_sel_ff == 2'h3) && push && !pop && (cnt == CW'(DEPTH - 1)) && ev_mask_ff[0] |=> irq_ff && ev_st_ff[0];
    endproperty
    a_thr_full: assert property (p_thr_full) else $error("Full threshold did not raise the interrupt.");

    property p_thr_3q;
        (thr_sel_ff == 2'h2) && push && !pop && (cnt == CW'(DEPTH * 3 / 4 - 1)) |=> ev_st_ff[0];
    endproperty
    a_thr_3q: assert property (p_thr_3q) else $error("Three-quarter threshold missed.");

    property p_thr_quiet;
        (thr_sel_ff == 2'h2) && !ev_st_ff[0] && (cnt == '0) && rx_char_valid_in && !wr |=> !ev_st_ff[0];
    endproperty
    a_thr_quiet: assert property (p_thr_quiet) else $error("Threshold event on first character.");

    property p_thr_any;
        !thr_sel_ff[1] && push |=> ev_st_ff[0];
    endproperty
    a_thr_any: assert property (p_thr_any) else $error("Per-character event missed.");

    property p_addr_filter;
        rx_char_valid_in && addr_det_ff && nine_bit_ff && !rx_char_in.data[8] |=> cnt <= $past(cnt);
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("Data character stored in address mode.");

    property p_idle;
        rx_busy_in [*2] |-> !idle_ff && !sta_word[4];
    endproperty
    a_idle: assert property (p_idle) else $error("Idle flag set during reception.");

    property p_head_flags;
        !empty |-> (sta_word[3] == head.parity_error_flag) && (sta_word[2] == head.framing_error_flag);
    endproperty
    a_head_flags: assert property (p_head_flags) else $error("Error flags do not follow the head.");

    property p_ovr_set;
        rx_char_valid_in && accept && full |=> ovr_ff ##0 (cnt == CW'(DEPTH)) || $past(pop);
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("Overrun not flagged.");

    property p_ovr_clear;
        $fell(ovr_ff) |-> (cnt == '0) && rx_flush_out;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("Overrun clear did not flush.");

    property p_avail;
        sta_word[0] == (cnt != '0);
    endproperty
    a_avail: assert property (p_avail) else $error("Data available flag wrong.");

    property p_ovr_hold;
        ovr_ff && rx_char_valid_in |=> cnt <= $past(cnt);
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("Character stored during overrun.");

    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held longer than one cycle.");

    // An error response only ever rides on a ready pulse, so a master never sees it alone.
    property p_err_ready;
        pslverr_out |-> pready_out;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("Error response without ready.");

    // Writing a one to the overrun bit must leave the flag and the buffer alone.
    property p_ovr_keep;
        wr && (paddr_in == `URS_OFS_STATUS) && pwdata_in[`URS_STA_OVR] && ovr_ff |=> ovr_ff;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("Overrun cleared by a one write.");

    // The shift-register reset is a single-cycle pulse; a longer one would eat the next start bit.
    property p_flush_pulse;
        rx_flush_out |=> !rx_flush_out;
    endproperty
    a_flush_pulse: assert property (p_flush_pulse) else $error("Flush pulse longer than one cycle.");

    // The interrupt line follows the masked event bits with no extra delay.
    property p_irq_level;
        irq_out == |(ev_st_ff & ev_mask_ff);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt does not match masked events.");

    c_fill_full: cover property ((thr_sel_ff == 2'h3) && thr_hit);
    c_ovr_flush: cover property ($fell(ovr_ff));
    c_filtered: cover property (rx_char_valid_in && !accept);
    c_irq: cover property ($rose(irq_out));

endmodule : urs_rx_status

`default_nettype wire

// >>> tb/urs_tx_model.sv
// Model of the remote transmitter as seen through the receive shift register.
// Assumes the receiver samples every line on the rising edge of clk_in.
`timescale 1ns/100ps
`default_nettype none

module urs_tx_model (
    input  wire logic                 clk_in,
    output logic                      valid_out,
    output var urs_pkg::urs_rx_char_s char_out,
    output logic                      busy_out
);
    urs_pkg::urs_rx_char_s last_ff;

    // Quiet link at time zero.
    initial begin
        valid_out = 1'b0;
        busy_out  = 1'b0;
        char_out  = '0;
        last_ff   = '0;
    end

    // One frame: busy while bits shift in, then a one-cycle handover pulse.
    // Outside the pulse the lines carry the inverse of the last character, so a
    // receiver that samples them late cannot match a stale value by luck.
    task send(input logic [8:0] d, input logic pe, input logic fe, input int len);
        @(posedge clk_in);
        busy_out <= 1'b1;
        repeat (len) @(posedge clk_in);
        last_ff = {fe, pe, d};
        valid_out <= 1'b1;
        char_out  <= last_ff;
        busy_out  <= 1'b0;
        @(posedge clk_in);
        valid_out <= 1'b0;
        char_out  <= ~last_ff;
    endtask : send
endmodule : urs_tx_model
`default_nettype wire

// >>> tb/tb_uart_receive_status.sv
// Self-checking bench of the receive status block over APB.
// Assumes urs_params.svh is on the include path and the transmitter model is compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "urs_params.svh"

module tb_uart_receive_status;
    localparam logic [7:0] a_sta = `URS_OFS_STATUS;
    localparam logic [7:0] a_ctl = `URS_OFS_CTRL;
    localparam logic [7:0] a_dat = `URS_OFS_DATA;
    localparam logic [7:0] a_ev  = `URS_OFS_EV_STATUS;
    localparam logic [7:0] a_msk = `URS_OFS_EV_MASK;
    logic                  clk_in = 1'b0;
    logic                  reset_in = 1'b1;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = '0;
    logic [31:0]           pwdata = '0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rx_valid;
    logic                  rx_busy;
    logic                  rx_flush;
    logic                  irq;
    urs_pkg::urs_rx_char_s rx_char;
    int                    n_errors = 0;
    int                    n_tests = 0;
    int                    n_flush = 0;
    int                    fl0;
    logic [31:0]           q;
    logic                  e;

    urs_rx_status #(.DEPTH(4)) dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rx_char_valid_in(rx_valid),
        .rx_char_in(rx_char), .rx_busy_in(rx_busy), .rx_flush_out(rx_flush), .irq_out(irq));
    urs_tx_model src (.clk_in(clk_in), .valid_out(rx_valid), .char_out(rx_char), .busy_out(rx_busy));

    // A 200 MHz clock.
    always #2.5 clk_in = ~clk_in;

    // Count shift-register reset pulses; each stands one cycle only.
    always @(posedge clk_in) if (rx_flush === 1'b1) n_flush++;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; starts at a fresh edge so no signal is assigned twice in one step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) chk("pready", 1, pready);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, '0);
        chk(nm, exp, q);
        chk({nm, " slverr"}, 0, e);
    endtask : rd_chk

    task automatic done_test(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, n_errors);
    endtask : done_test

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // The tests need well under 2000 cycles; this cuts a hang short.
    initial begin
        #100000;
        n_errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_chk(a_sta, 32'h10, "status reset");
        rd_chk(a_ctl, 32'h0, "ctrl reset");
        rd_chk(a_ev, 32'h0, "event reset");
        rd_chk(a_msk, 32'h0, "mask reset");
        rd_chk(a_dat, 32'h0, "data empty");
        apb(1'b0, 8'h14, '0);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, q);
        done_test("reset");
        // Select codes 00 and 01 both fire on every character.
        wr(a_msk, 32'h3);
        for (int s = 0; s < 2; s++) begin
            wr(a_sta, 32'(s) << 6);
            src.send(9'h0a5, 1'b1, 1'b0, 3);
            src.send(9'h05a, 1'b0, 1'b1, 3);
            repeat (2) @(posedge clk_in);
            chk("irq any", 1, irq);
            rd_chk(a_ev, 32'h1, "event any");
            rd_chk(a_sta, (32'(s) << 6) | 32'h19, "status parity head");
            rd_chk(a_dat, 32'h0a5, "data first");
            rd_chk(a_sta, (32'(s) << 6) | 32'h15, "status framing head");
            rd_chk(a_dat, 32'h05a, "data second");
            rd_chk(a_sta, (32'(s) << 6) | 32'h10, "status drained");
            wr(a_ev, 32'h3);
            repeat (2) @(posedge clk_in);
            chk("irq cleared", 0, irq);
        end
        done_test("any");
        wr(a_sta, 32'h80);
        src.send(9'h101, 1'b0, 1'b0, 2);
        src.send(9'h102, 1'b0, 1'b0, 2);
        rd_chk(a_ev, 32'h0, "event at two");
        src.send(9'h103, 1'b0, 1'b0, 2);
        rd_chk(a_ev, 32'h1, "event at three");
        wr(a_ev, 32'h3);
        rd_chk(a_dat, 32'h101, "data oldest");
        wr(a_sta, 32'hc0);
        src.send(9'h104, 1'b0, 1'b0, 2);
        rd_chk(a_ev, 32'h0, "event full at three");
        src.send(9'h105, 1'b0, 1'b0, 2);
        rd_chk(a_ev, 32'h1, "event full at four");
        done_test("threshold");
        wr(a_ev, 32'h3);
        src.send(9'h106, 1'b0, 1'b0, 2);
        rd_chk(a_sta, 32'hd3, "status overrun");
        rd_chk(a_ev, 32'h2, "event overrun");
        chk("irq overrun", 1, irq);
        rd_chk(a_dat, 32'h102, "data after overrun");
        src.send(9'h107, 1'b0, 1'b0, 2);
        rd_chk(a_dat, 32'h103, "data keep order");
        rd_chk(a_dat, 32'h104, "data keep order");
        rd_chk(a_dat, 32'h105, "data keep order");
        rd_chk(a_sta, 32'hd2, "no store in overrun");
        fl0 = n_flush;
        wr(a_sta, 32'hc2);
        rd_chk(a_sta, 32'hd2, "overrun write one");
        wr(a_sta, 32'hc0);
        rd_chk(a_sta, 32'hd0, "overrun cleared");
        for (int i = 0; i < 5; i++) src.send(9'h110 + 9'(i), 1'b0, 1'b0, 2);
        rd_chk(a_sta, 32'hd3, "overrun again");
        wr(a_sta, 32'hc0);
        rd_chk(a_sta, 32'hd0, "flush empties");
        rd_chk(a_dat, 32'h0, "flush data");
        chk("flush pulses", 32'(fl0 + 2), 32'(n_flush));
        wr(a_ev, 32'h3);
        done_test("overrun");
        wr(a_ctl, 32'h1);
        wr(a_sta, 32'h20);
        src.send(9'h033, 1'b0, 1'b0, 2);
        rd_chk(a_sta, 32'h30, "data char filtered");
        src.send(9'h1c4, 1'b0, 1'b0, 2);
        rd_chk(a_dat, 32'h1c4, "address char kept");
        wr(a_ctl, 32'h0);
        src.send(9'h033, 1'b0, 1'b0, 2);
        rd_chk(a_dat, 32'h033, "eight bit unfiltered");
        done_test("address");
        fork
            src.send(9'h077, 1'b0, 1'b0, 20);
            begin
                repeat (6) @(posedge clk_in);
                rd_chk(a_sta, 32'h20, "idle while busy");
            end
        join
        rd_chk(a_sta, 32'h31, "idle after frame");
        done_test("idle");
        complete_run();
    end
endmodule : tb_uart_receive_status
`default_nettype wire
